// [pkg/tsec_pkg.sv]
package tsec_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CHAN = 64;      // Peripheral channels
    localparam int NUM_EVT  = 16;      // Core event classes
    localparam int NUM_GEN  = 9;       // General-purpose levels
    localparam int GEN_BASE = 7;       // Event bit of the first level
    localparam int FIELD_W  = 4;       // Routing field per channel

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_LATCH   = 8'h00;
    localparam logic [7:0] OFS_MASK    = 8'h04;
    localparam logic [7:0] OFS_PEND    = 8'h08;
    localparam logic [7:0] OFS_CTRL    = 8'h0c;
    localparam logic [7:0] OFS_PMASK_L = 8'h10;
    localparam logic [7:0] OFS_PMASK_H = 8'h14;
    localparam logic [7:0] OFS_PSTAT_L = 8'h18;
    localparam logic [7:0] OFS_PSTAT_H = 8'h1c;
    localparam logic [7:0] OFS_PWAKE_L = 8'h20;
    localparam logic [7:0] OFS_PWAKE_H = 8'h24;
    localparam logic [7:0] OFS_ASSIGN0 = 8'h40;  // Eight words up to 8'h5c
    localparam logic [7:0] OFS_ASSIGN7 = 8'h5c;

    // ==========================================================
    // Field layouts and reset values
    localparam int         EVT_GLOBAL   = 4;          // Global enable slot, no event
    localparam int         CTRL_GIE_BIT = 0;
    localparam int         CTRL_WAKE_BIT = 1;
    localparam logic [15:0] LATCH_VALID = 16'hffef;
    localparam logic [15:0] MASK_FIXED  = 16'h000f;   // Always unmasked classes
    localparam logic [15:0] MASK_WR     = 16'hffe0;   // Software-writable mask bits
    localparam logic [15:0] MASK_RESET  = 16'h001f;
    localparam logic [15:0] GEN_BITS    = 16'hff80;
    localparam logic [15:0] EVT_RESET   = 16'h0000;
    localparam logic [63:0] PMASK_RESET = 64'h0;
    localparam logic [63:0] PWAKE_RESET = 64'h0;
    localparam logic        GIE_RESET   = 1'b1;
    localparam logic [7:0][31:0] ASSIGN_RESET = {
        32'h00006552, 32'h21144444, 32'h43333333, 32'h33333222,
        32'h22222222, 32'h21111111, 32'h11111000, 32'h00000000};

    // ==========================================================
    // Register selector and captured bus access
    typedef enum logic [3:0] {
        R_NONE    = 4'h0, R_LATCH   = 4'h1, R_MASK    = 4'h2, R_PEND    = 4'h3,
        R_CTRL    = 4'h4, R_PMASK_L = 4'h5, R_PMASK_H = 4'h6, R_PSTAT_L = 4'h7,
        R_PSTAT_H = 4'h8, R_PWAKE_L = 4'h9, R_PWAKE_H = 4'ha, R_ASSIGN  = 4'hb
    } tsec_reg_e_t;

    typedef struct packed {
        logic        wr;
        logic        priv;
        tsec_reg_e_t sel;
        logic [2:0]  aidx;
    } tsec_acc_t;

    // Highest-priority (lowest index) set bit: {valid, index}
    function automatic logic [4:0] tsec_first(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

endpackage

// [test/tsec_pipe_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Pipeline partner: accepts requests, returns from them later
module tsec_pipe_model (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic       req_i,
    input  wire logic [3:0] lat_i,
    input  wire logic [3:0] hold_i,
    output logic            ack_o,
    output logic            ret_o
);
    logic [3:0] wait_reg;
    logic [3:0] ret_reg;

    // Acknowledge a standing request after lat_i cycles
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 4'h0;
            ack_o    <= 1'b0;
        end else begin
            ack_o    <= req_i && !ack_o && (wait_reg == lat_i);
            wait_reg <= (req_i && !ack_o && wait_reg != lat_i) ? wait_reg + 4'h1 : 4'h0;
        end
    end

    // Return after hold_i cycles; zero keeps the event nested
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ret_reg <= 4'h0;
            ret_o   <= 1'b0;
        end else begin
            ret_reg <= (ack_o && req_i) ? hold_i : (ret_reg != 4'h0 ? ret_reg - 4'h1 : 4'h0);
            ret_o   <= (ret_reg == 4'h1);
        end
    end
endmodule

// [test/tsec_top_asserts.sv]
`timescale 1ns/10ps
// ==========================================================
// Port checker for the event controller
module tsec_top_asserts import tsec_pkg::*; (
    input  wire logic                mclk_i,
    input  wire logic                reset_n_i,
    input  wire logic                clk_en_i,
    input  wire logic                hsel_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hready_i,
    input  wire logic [31:0]         hrdata_o,
    input  wire logic                hreadyout_o,
    input  wire logic                hresp_o,
    input  wire logic [NUM_CHAN-1:0] periph_irq_i,
    input  wire logic                event_ack_i,
    input  wire logic                event_ret_i,
    input  wire logic                event_req_o,
    input  wire logic [3:0]          event_id_o,
    input  wire logic [NUM_EVT-1:0]  event_pending_o,
    input  wire logic                wake_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // Register bus answers
    chk_resp_okay: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    chk_ready_up: assert property ($past(reset_n_i) && $past(clk_en_i) |-> hreadyout_o)
        else $error("bus not ready after reset");
    chk_rdata_idle: assert property (clk_en_i && !(hsel_i && htrans_i[1] && hready_i) |=> hrdata_o == 32'h0)
        else $error("read data left standing");

    // Acknowledge moves the event into pending
    chk_req_drop: assert property (clk_en_i && event_req_o && event_ack_i |=> !event_req_o)
        else $error("request stays after acknowledge");
    chk_pend_on_ack: assert property (clk_en_i && event_req_o && event_ack_i |=> event_pending_o[$past(event_id_o)])
        else $error("pending bit not set on acknowledge");
    chk_pend_source: assert property ((event_pending_o & ~$past(event_pending_o)) != 16'h0 |-> $past(event_req_o && event_ack_i))
        else $error("pending bit set without acknowledge");
    chk_ret_pop: assert property (clk_en_i && event_ret_i && !event_ack_i && event_pending_o != 16'h0
        |=> $countones(event_pending_o) == $countones($past(event_pending_o)) - 1)
        else $error("return did not clear one level");

    // Wakeup follows an asserting source
    chk_wake_src: assert property (wake_o |-> $past(periph_irq_i, 2) != 64'h0)
        else $error("wakeup without a source");
endmodule

bind tsec_top tsec_top_asserts u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .periph_irq_i(periph_irq_i), .event_ack_i(event_ack_i),
    .event_ret_i(event_ret_i), .event_req_o(event_req_o), .event_id_o(event_id_o),
    .event_pending_o(event_pending_o), .wake_o(wake_o));

// [test/tsec_top_tb_top.sv]
`timescale 1ns/10ps
// ==========================================================
// Bench for the two-stage event controller
module tsec_top_tb_top import tsec_pkg::*;;
    logic        clk, rst_n, hsel, hwr, hrdy, hresp, req, ack, ret, wake, gon, goff;
    logic [1:0]  htr;
    logic [3:0]  hprot, id, lat, hold;
    logic [6:0]  cev;
    logic [31:0] haddr, hwd, hrd, rd, seed;
    logic [63:0] irq;
    logic [15:0] pend;
    int          miscompares, n_compared, c;

    tsec_top DUT (.mclk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hprot_i(hprot), .hwdata_i(hwd), .hready_i(hrdy),
        .hrdata_o(hrd), .hreadyout_o(hrdy), .hresp_o(hresp), .periph_irq_i(irq), .core_event_i(cev),
        .global_irq_on_instr_i(gon), .global_irq_off_instr_i(goff), .event_ack_i(ack), .event_ret_i(ret),
        .event_req_o(req), .event_id_o(id), .event_pending_o(pend), .wake_o(wake));
    tsec_pipe_model u_pipe (.mclk_i(clk), .reset_n_i(rst_n), .req_i(req), .lat_i(lat), .hold_i(hold),
        .ack_o(ack), .ret_o(ret));

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Helpers: random source, default levels, comparison, bus cycles
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [3:0] lvl(input int ch);
        return (ch < 53) ? 4'hb : (ch < 55) ? 4'h8 : (ch < 57) ? 4'h9 : 4'hc;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel  <= 1'b1;
        haddr <= {24'h0, a};
        htr   <= 2'b10;
        hwr   <= w;
        do @(posedge clk); while (!hrdy);
        hsel <= 1'b0;
        htr  <= 2'b00;
        hwd  <= d;
        do @(posedge clk); while (!hrdy);
        rd = hrd;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wpend(input int b);
        c = 0;
        while (pend[b] !== 1'b1 && c < 60) begin
            @(posedge clk);
            c++;
        end
        if (c >= 60) miscompares++;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        tick(5);
        rst_n <= 1'b1;
        tick(2);
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        tick(20000);
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rst_n, hsel, hwr, gon, goff, cev} = 12'h000;
        {htr, haddr, hwd, irq} = 0;
        {hprot, lat, hold, seed} = {4'h3, 4'h2, 4'hf, 32'h000121dc};
        do_reset();
        rdc(OFS_MASK, 32'h1f);
        rdc(OFS_PEND, 32'h0);
        for (int ch = 47; ch < 59; ch++) begin
            bus(1'b0, OFS_ASSIGN0 + 8'(4 * (ch / 8)), 32'h0);
            chk((rd >> (4 * (ch % 8))) & 32'hf, 32'(lvl(ch) - 4'h7));
        end
        rdc(8'h80, 32'h0);
        hprot <= 4'h1;
        bus(1'b1, OFS_MASK, 32'hff80);
        rdc(OFS_MASK, 32'h0);
        hprot <= 4'h3;
        rdc(OFS_MASK, 32'h1f);
        repeat (4) begin
            seed = lfsr(seed);
            irq <= {lfsr(seed), seed};
            tick(2);
            rdc(OFS_PSTAT_L, irq[31:0]);
            rdc(OFS_PSTAT_H, irq[63:32]);
        end
        irq <= 64'h0;
        bus(1'b1, OFS_ASSIGN0, 32'h4);
        bus(1'b1, OFS_PMASK_L, 32'h1);
        bus(1'b1, OFS_PWAKE_L, 32'h1);
        bus(1'b1, OFS_MASK, 32'h0800);
        irq[47] <= 1'b1;
        tick(8);
        chk(32'(req), 32'h0);
        irq[0] <= 1'b1;
        wpend(11);
        chk(32'(c >= 3), 32'h1);
        chk(32'(pend), 32'h0800);
        chk(32'(wake), 32'h1);
        irq[0] <= 1'b0;
        tick(1);
        irq[0] <= 1'b1;
        tick(4);
        rdc(OFS_LATCH, 32'h0800);
        irq[0] <= 1'b0;
        tick(60);
        rdc(OFS_LATCH, 32'h0);
        rdc(OFS_PEND, 32'h0);
        bus(1'b1, OFS_MASK, 32'h0);
        irq[0] <= 1'b1;
        tick(6);
        chk(32'(req), 32'h0);
        rdc(OFS_LATCH, 32'h0800);
        bus(1'b1, OFS_LATCH, 32'h0);
        rdc(OFS_LATCH, 32'h0);
        {irq[0], lat, hold, goff} <= {1'b0, 4'h0, 4'h1, 1'b1};
        tick(1);
        goff <= 1'b0;
        bus(1'b1, OFS_MASK, 32'h0800);
        irq[0] <= 1'b1;
        tick(8);
        chk(32'(req), 32'h0);
        gon <= 1'b1;
        tick(1);
        gon <= 1'b0;
        wpend(11);
        chk(32'(pend[11]), 32'h1);
        cev[2] <= 1'b1;
        wpend(2);
        chk(32'(pend[2]), 32'h1);
        {irq[0], cev} <= {1'b0, 7'h00};
        do_reset();
        rdc(OFS_PMASK_L, 32'h0);
        rdc(OFS_MASK, 32'h1f);
        print_verdict();
    end
endmodule

// [verilog/tsec_edge_det.sv]
`timescale 1ns/10ps
module tsec_edge_det import tsec_pkg::*; (
    input  wire logic                 mclk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 clk_en_i,
    input  wire logic [NUM_EVT-1:0]   level_i,
    input  wire logic [NUM_EVT-1:0]   rearm_i,
    output logic      [NUM_EVT-1:0]   rise_o
);

    // ==========================================================
    // Two-cycle rising edge detection
    logic [NUM_EVT-1:0] now_reg;
    logic [NUM_EVT-1:0] old_reg;

    // Sample, then remember; rearm forgets a held level so it counts again
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            now_reg <= '0;
            old_reg <= '0;
        end else if (clk_en_i) begin
            now_reg <= level_i;
            old_reg <= now_reg & ~rearm_i;
        end
    end

    assign rise_o = now_reg & ~old_reg;

endmodule

// [verilog/tsec_sys_route.sv]
`timescale 1ns/10ps
module tsec_sys_route import tsec_pkg::*; (
    input  wire logic [NUM_CHAN-1:0]         irq_i,
    input  wire logic [NUM_CHAN-1:0]         mask_i,
    input  wire logic [NUM_CHAN*FIELD_W-1:0] route_i,
    output logic      [NUM_GEN-1:0]          level_req_o
);

    // ==========================================================
    // Per-level OR of unmasked channels routed to that level
    logic [NUM_GEN-1:0][NUM_CHAN-1:0] hit;

    for (genvar l = 0; l < NUM_GEN; l++) begin : g_level
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
            assign hit[l][c] = irq_i[c] & mask_i[c]
                             & (route_i[c*FIELD_W +: FIELD_W] == FIELD_W'(l));
        end
        assign level_req_o[l] = |hit[l];
    end

endmodule

// [verilog/tsec_top.sv]
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
// How it works
// - After reset, channels 47 to 52 route to level eleven.
// - After reset, channels 53,54 route to level eight; 55,56 to level nine.
// - After reset, channels 57 and 58 route to level twelve.
// - Core stage holds sixteen-bit latch, mask and pending registers.
// - Latch bit sets on capture, clears when the event is accepted.
// - Software latch writes take effect only where the mask bit is clear.
// - Mask one lets a latched event be serviced; zero keeps it latched.
// - Mask register is read and written only in supervisor mode.
// - Global general-purpose enable, set by on and cleared by off instruction.
// - Pending shows active or nested events; controller-updated, supervisor readable.
// - Six 32-bit system registers: mask, status, wakeup enable, two each.
// - Unmasked asserted channel is forwarded; masked channel is blocked.
// - Status bit reads one while its peripheral asserts its interrupt.
// - Wakeup-enabled channel event wakes the processor from power-down.
// - Simultaneous pulses on a shared level, even during handling, are tolerated.
// - Pending contents act as acknowledgement for a routed level.
// - Level latch bit sets on a rising edge detected in two cycles.
// - Latch bit clears when its pending bit becomes set.
// - After pending sets, a further rising edge is caught and queued.
// - Pending asserts no sooner than three cycles after an input edge.
// - Software rewrites the channel-to-level assignment registers.
// - Nine general levels plus emulation, reset, NMI, exception, error, timer.
module tsec_top import tsec_pkg::*; (
    input  wire logic                mclk_i,
    input  wire logic                reset_n_i,
    input  wire logic                clk_en_i,
    input  wire logic                hsel_i,
    input  wire logic [31:0]         haddr_i,
    input  wire logic [1:0]          htrans_i,
    input  wire logic                hwrite_i,
    input  wire logic [2:0]          hsize_i,
    input  wire logic [3:0]          hprot_i,
    input  wire logic [31:0]         hwdata_i,
    input  wire logic                hready_i,
    output logic      [31:0]         hrdata_o,
    output logic                     hreadyout_o,
    output logic                     hresp_o,
    input  wire logic [NUM_CHAN-1:0] periph_irq_i,
    input  wire logic [6:0]          core_event_i,
    input  wire logic                global_irq_on_instr_i,
    input  wire logic                global_irq_off_instr_i,
    input  wire logic                event_ack_i,
    input  wire logic                event_ret_i,
    output logic                     event_req_o,
    output logic      [3:0]          event_id_o,
    output logic      [NUM_EVT-1:0]  event_pending_o,
    output logic                     wake_o
);

    // ==========================================================
    // Address decode shared by the read and write paths
    function automatic tsec_acc_t tsec_decode(input logic [7:0] a, input logic wr, input logic priv);
        tsec_acc_t r;
        r.wr   = wr;
        r.priv = priv;
        r.aidx = a[4:2];
        case (a & 8'hfc)
            OFS_LATCH:   r.sel = R_LATCH;
            OFS_MASK:    r.sel = R_MASK;
            OFS_PEND:    r.sel = R_PEND;
            OFS_CTRL:    r.sel = R_CTRL;
            OFS_PMASK_L: r.sel = R_PMASK_L;
            OFS_PMASK_H: r.sel = R_PMASK_H;
            OFS_PSTAT_L: r.sel = R_PSTAT_L;
            OFS_PSTAT_H: r.sel = R_PSTAT_H;
            OFS_PWAKE_L: r.sel = R_PWAKE_L;
            OFS_PWAKE_H: r.sel = R_PWAKE_H;
            default: begin
                if ((a >= OFS_ASSIGN0) && (a <= OFS_ASSIGN7)) begin
                    r.sel = R_ASSIGN;
                end else begin
                    r.sel = R_NONE;
                end
            end
        endcase
        return r;
    endfunction

    // ==========================================================
    // State
    tsec_acc_t                  acc_reg;
    logic [NUM_EVT-1:0]         latch_reg;
    logic [NUM_EVT-1:0]         mask_reg;
    logic [NUM_EVT-1:0]         pend_reg;
    logic                       gie_reg;
    logic [NUM_CHAN-1:0]        pmask_reg;
    logic [NUM_CHAN-1:0]        pstat_reg;
    logic [NUM_CHAN-1:0]        pwake_reg;
    logic [7:0][31:0]           assign_reg;
    logic                       req_reg;
    logic [3:0]                 id_reg;
    logic                       wake_reg;
    logic [31:0]                rdata_reg;

    // ==========================================================
    // Combinational signals
    logic                       addr_phase;
    tsec_acc_t                  acc_next;
    logic                       wr_priv;
    logic [NUM_GEN-1:0]         level_req;
    logic [NUM_EVT-1:0]         evt_level;
    logic [NUM_EVT-1:0]         rise;
    logic [NUM_EVT-1:0]         pend_set;
    logic [NUM_EVT-1:0]         pend_clr;
    logic [NUM_EVT-1:0]         latch_next;
    logic [NUM_EVT-1:0]         pend_next;
    logic [NUM_EVT-1:0]         eligible;
    logic [NUM_EVT-1:0]         gen_gate;
    logic [4:0]                 sel_first;
    logic [4:0]                 cur_first;
    logic                       sel_ok;
    logic                       ack_taken;
    logic [31:0]                rdata_next;

    // ==========================================================
    // Bus address phase: word transfers only, privilege from hprot
    assign addr_phase = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'b010);
    assign acc_next   = addr_phase ? tsec_decode(haddr_i[7:0], hwrite_i, hprot_i[1])
                                   : tsec_acc_t'{wr: 1'b0, priv: 1'b0, sel: R_NONE, aidx: 3'h0};
    assign wr_priv    = acc_reg.wr & acc_reg.priv;

    // Capture the access for its data phase
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_reg <= '{wr: 1'b0, priv: 1'b0, sel: R_NONE, aidx: 3'h0};
        end else if (clk_en_i) begin
            acc_reg <= acc_next;
        end
    end

    // Zero-wait slave that always answers OKAY
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
        end else if (clk_en_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ==========================================================
    // System stage
    tsec_sys_route u_route (
        .irq_i       (periph_irq_i),
        .mask_i      (pmask_reg),
        .route_i     (assign_reg),
        .level_req_o (level_req)
    );

    // Peripheral status follows the raw request lines
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pstat_reg <= '0;
        end else if (clk_en_i) begin
            pstat_reg <= periph_irq_i;
        end
    end

    // Wakeup request from enabled, asserting channels
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_reg <= 1'b0;
        end else if (clk_en_i) begin
            wake_reg <= |(pstat_reg & pwake_reg);
        end
    end

    // Peripheral mask and wakeup enables, low and high words
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pmask_reg <= PMASK_RESET;
            pwake_reg <= PWAKE_RESET;
        end else if (clk_en_i && acc_reg.wr) begin
            case (acc_reg.sel)
                R_PMASK_L: pmask_reg[31:0]  <= hwdata_i;
                R_PMASK_H: pmask_reg[63:32] <= hwdata_i;
                R_PWAKE_L: pwake_reg[31:0]  <= hwdata_i;
                R_PWAKE_H: pwake_reg[63:32] <= hwdata_i;
                default:   pmask_reg        <= pmask_reg;
            endcase
        end
    end

    // Channel-to-level assignment, defaults give the reset routing
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            assign_reg <= ASSIGN_RESET;
        end else if (clk_en_i && acc_reg.wr && (acc_reg.sel == R_ASSIGN)) begin
            assign_reg[acc_reg.aidx] <= hwdata_i;
        end
    end

    // ==========================================================
    // Core stage inputs: dedicated events low, routed levels high
    always_comb begin
        evt_level                             = '0;
        evt_level[6:0]                        = core_event_i;
        evt_level[EVT_GLOBAL]                 = 1'b0;
        evt_level[GEN_BASE +: NUM_GEN]        = level_req;
    end

    // Pending set re-arms the detector so a held or shared level counts again
    tsec_edge_det u_edge (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .level_i   (evt_level),
        .rearm_i   (pend_set),
        .rise_o    (rise)
    );

    // ==========================================================
    // Service selection with nesting against the current pending level
    assign gen_gate  = gie_reg ? 16'hffff : ~GEN_BITS;
    assign eligible  = latch_reg & (mask_reg | MASK_FIXED) & gen_gate;
    assign sel_first = tsec_first(eligible);
    assign cur_first = tsec_first(pend_reg);
    assign sel_ok    = sel_first[4] & (!cur_first[4] || (sel_first[3:0] < cur_first[3:0]));
    assign ack_taken = event_ack_i & req_reg & latch_reg[id_reg];

    // Request to the pipeline, dropped on the acknowledge edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_reg <= 1'b0;
            id_reg  <= 4'h0;
        end else if (clk_en_i) begin
            req_reg <= sel_ok & ~ack_taken;
            id_reg  <= sel_first[3:0];
        end
    end

    // Acknowledge enters the pending set; return unwinds the top level
    always_comb begin
        pend_set = '0;
        pend_clr = '0;
        if (ack_taken) begin
            pend_set[id_reg] = 1'b1;
        end
        if (event_ret_i && cur_first[4]) begin
            pend_clr[cur_first[3:0]] = 1'b1;
        end
    end

    assign pend_next = (pend_reg & ~pend_clr) | pend_set;

    // Pending register, controller-owned
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend_reg <= EVT_RESET;
        end else if (clk_en_i) begin
            pend_reg <= pend_next;
        end
    end

    // Latch next value: software, then accept clear, then edge set wins
    always_comb begin
        latch_next = latch_reg;
        if (wr_priv && (acc_reg.sel == R_LATCH)) begin
            latch_next = (latch_reg & mask_reg) | (hwdata_i[15:0] & ~mask_reg);
        end
        latch_next = latch_next & ~pend_set;
        latch_next = (latch_next | rise) & LATCH_VALID;
    end

    // Latch register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latch_reg <= EVT_RESET;
        end else if (clk_en_i) begin
            latch_reg <= latch_next;
        end
    end

    // Mask register, supervisor writes only
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_reg <= MASK_RESET;
        end else if (clk_en_i && wr_priv && (acc_reg.sel == R_MASK)) begin
            mask_reg <= (hwdata_i[15:0] & MASK_WR) | MASK_RESET;
        end
    end

    // Global enable from the on and off instructions; off wins a tie
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gie_reg <= GIE_RESET;
        end else if (clk_en_i) begin
            if (global_irq_off_instr_i) begin
                gie_reg <= 1'b0;
            end else if (global_irq_on_instr_i) begin
                gie_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read data, chosen in the address phase; core registers need privilege
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (acc_next.sel)
            R_LATCH:   rdata_next = acc_next.priv ? {16'h0000, latch_reg} : 32'h0000_0000;
            R_MASK:    rdata_next = acc_next.priv ? {16'h0000, mask_reg} : 32'h0000_0000;
            R_PEND:    rdata_next = acc_next.priv ? {16'h0000, pend_reg} : 32'h0000_0000;
            R_CTRL: begin
                rdata_next[CTRL_GIE_BIT]  = gie_reg;
                rdata_next[CTRL_WAKE_BIT] = wake_reg;
            end
            R_PMASK_L: rdata_next = pmask_reg[31:0];
            R_PMASK_H: rdata_next = pmask_reg[63:32];
            R_PSTAT_L: rdata_next = pstat_reg[31:0];
            R_PSTAT_H: rdata_next = pstat_reg[63:32];
            R_PWAKE_L: rdata_next = pwake_reg[31:0];
            R_PWAKE_H: rdata_next = pwake_reg[63:32];
            R_ASSIGN:  rdata_next = assign_reg[acc_next.aidx];
            default:   rdata_next = 32'h0000_0000;
        endcase
        if (acc_next.wr) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // Read data register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (clk_en_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // Outputs straight from flip-flops
    assign hrdata_o        = rdata_reg;
    assign event_req_o     = req_reg;
    assign event_id_o      = id_reg;
    assign event_pending_o = pend_reg;
    assign wake_o          = wake_reg;

endmodule
